// ==== hdl/clk_ctrl_pkg.sv ====
// Constants, register layout and types for the clock select and prescaler block
//
// Notes on behaviour
// - Slow clock from prescaled main clock when select is 0, else 32.768 kHz oscillator.
// - Fast select 0 feeds system prescaler from PLL, 1 from main; resets to main.
// - Clearing fast select is ignored while PLL power-down is set.
// - Switch to PLL needs a stable PLL at the write; fast select stays set otherwise.
// - PLL held down while power-down bit is 1; bit resets to 1.
// - Setting power-down is ignored while system clock runs from the PLL.
// - Aux clock 1 runs only when enabled and main clock stable; enable resets 0.
// - Aux clock 2 runs only when enabled and main clock stable; enable resets 0.
// - Power-on flag set by hardware; software clears by writing 0 only.
// - System clock is selected source divided by fast divisor plus one.
// - Multiplier codes 011, 100, 101 give 3x, 4x, 5x; others reserved; reset 100.
// - Fast prescaler resets to 4Fh except in programming mode.
// - Slow clock is main divided by two times slow divisor plus one; reset B6h.
// - Aux clock 1 is main divided by its divisor plus one; register resets FFh.
// - Aux clock 2 is main divided by its divisor plus one.
// - Per mode: system clock from fast prescaler (main or PLL), slow, or none; timer clock slow or none.
// - Low-frequency oscillator always runs; slow clock frozen in halt mode.
// - Oscillator off in power save only while slow clock comes from the oscillator.
// - Wait stalls the processor until an interrupt; reset enters active mode.
package clk_ctrl_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] CLOCK_RESET_CONTROL_OFS = 8'h40;
	localparam logic [7:0] FAST_CLOCK_PRESCALER_OFS = 8'h42;
	localparam logic [7:0] SLOW_CLOCK_PRESCALER_OFS = 8'h44;
	localparam logic [7:0] AUX_CLOCK_PRESCALER_OFS = 8'h46;

	// Control register bit positions
	localparam int SLOW_SEL_BIT = 0;
	localparam int FAST_SEL_BIT = 1;
	localparam int PLL_PWD_BIT = 2;
	localparam int AUX1_EN_BIT = 3;
	localparam int AUX2_EN_BIT = 4;
	localparam int POR_BIT = 5;

	// Values after reset
	localparam logic [7:0] CLOCK_RESET_CONTROL_RST = 8'h26;
	localparam logic [6:0] FAST_CLOCK_PRESCALER_RST = 7'h4f;
	localparam logic [6:0] FAST_CLOCK_PRESCALER_PROGRAMMING_MODE_RST = 7'h40;
	localparam logic [7:0] SLOW_CLOCK_PRESCALER_RST = 8'hb6;
	localparam logic [7:0] AUX_CLOCK_PRESCALER_RST = 8'hff;

	// PLL multiplier codes
	localparam logic [2:0] PLL_MULT_3X = 3'h3;
	localparam logic [2:0] PLL_MULT_4X = 3'h4;
	localparam logic [2:0] PLL_MULT_5X = 3'h5;

	// Power management modes, as reported by the power manager
	typedef enum logic [1:0] {
		PM_ACTIVE,
		PM_SAVE,
		PM_IDLE,
		PM_HALT
	} pm_mode_t;

	// Clock and reset control register fields
	typedef struct packed {
		logic [1:0] rsvd;
		logic por;
		logic aux2_enable;
		logic aux1_enable;
		logic pll_power_down;
		logic fast_source_select;
		logic slow_source_select;
	} clock_reset_control_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage : clk_ctrl_pkg

// ==== hdl/clk_ctrl.sv ====
// Clock source selection, prescalers and per-mode clock gating
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl
	import clk_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Clock sources and status
	input wire logic main_stable_i,
	input wire logic pll_tick_i,
	input wire logic pll_stable_i,
	input wire logic lfo_clk_i,
	input wire logic power_on_i,
	input wire logic programming_mode_i,
	// Power manager and processor
	input wire logic [1:0] pm_mode_i,
	input wire logic hf_off_req_i,
	input wire logic wait_i,
	input wire logic irq_i,
	// Generated clocks as enables
	output logic sys_tick_o,
	output logic timer_tick_o,
	output logic slow_clk_o,
	output logic aux1_tick_o,
	output logic aux2_tick_o,
	// PLL and oscillator control
	output logic pll_stop_o,
	output logic [2:0] pll_mult_o,
	output logic fast_src_main_o,
	output logic hf_osc_en_o,
	output logic cpu_stall_o,
	output logic [1:0] pm_mode_o
);

	// Register state
	clock_reset_control_t ctl_r;
	clock_reset_control_t ctl_nxt;
	logic [6:0] fast_presc_r;
	logic [7:0] slow_presc_r;
	logic [7:0] aux_presc_r;
	logic [7:0] rdata_r;
	reg_req_t req;

	// Prescaler state
	logic [3:0] fast_cnt_r;
	logic [7:0] slow_cnt_r;
	logic [3:0] aux1_cnt_r;
	logic [3:0] aux2_cnt_r;
	logic slow_div_r;
	logic slow_src_r;
	logic slow_clk_r;
	logic lfo_r;
	logic fast_tick_r;
	logic sys_tick_r;
	logic timer_tick_r;
	logic aux1_tick_r;
	logic aux2_tick_r;
	logic pll_stop_r;
	logic hf_osc_en_r;
	logic cpu_stall_r;
	pm_mode_t mode_r;

	// Request bundle
	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	// Address decode
	wire logic sel_ctl = req.addr == CLOCK_RESET_CONTROL_OFS;
	wire logic sel_fast = req.addr == FAST_CLOCK_PRESCALER_OFS;
	wire logic sel_slow = req.addr == SLOW_CLOCK_PRESCALER_OFS;
	wire logic sel_aux = req.addr == AUX_CLOCK_PRESCALER_OFS;
	wire logic wr_ctl = req.wr && sel_ctl;
	wire logic wr_fast = req.wr && sel_fast;
	wire logic wr_slow = req.wr && sel_slow;
	wire logic wr_aux = req.wr && sel_aux;

	// Field views of the prescaler registers
	wire logic [3:0] fast_divisor = fast_presc_r[3:0];
	wire logic [2:0] pll_mult = fast_presc_r[6:4];
	wire logic [7:0] slow_divisor = slow_presc_r;
	wire logic [3:0] aux1_divisor = aux_presc_r[3:0];
	wire logic [3:0] aux2_divisor = aux_presc_r[7:4];

	// Written control bits
	wire logic w_slow_sel = req.wdata[SLOW_SEL_BIT];
	wire logic w_fast_sel = req.wdata[FAST_SEL_BIT];
	wire logic w_pll_pwd = req.wdata[PLL_PWD_BIT];
	wire logic w_por = req.wdata[POR_BIT];

	// Clearing fast select only lands once the PLL is up and stable
	wire logic fast_to_pll_ok = !ctl_r.pll_power_down && pll_stable_i;
	wire logic fast_sel_wr = w_fast_sel || !fast_to_pll_ok;
	// Powering the PLL down while running on it would kill the clock
	wire logic pll_pwd_wr = w_pll_pwd && ctl_r.fast_source_select;

	// Control register next value; power-on set wins over a clear
	always_comb
	begin
		ctl_nxt = ctl_r;
		if (wr_ctl)
		begin
			ctl_nxt.slow_source_select = w_slow_sel;
			ctl_nxt.fast_source_select = fast_sel_wr;
			ctl_nxt.pll_power_down = pll_pwd_wr;
			ctl_nxt.aux1_enable = req.wdata[AUX1_EN_BIT];
			ctl_nxt.aux2_enable = req.wdata[AUX2_EN_BIT];
			if (!w_por)
				ctl_nxt.por = 1'b0;
		end
		if (power_on_i)
			ctl_nxt.por = 1'b1;
		ctl_nxt.rsvd = 2'h0;
	end

	// Control register; reset selects main clock with PLL down
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ctl_r <= clock_reset_control_t'(CLOCK_RESET_CONTROL_RST);
		else
			ctl_r <= ctl_nxt;
	end

	// Prescaler registers; programming mode keeps its own fast setting
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			if (programming_mode_i)
				fast_presc_r <= FAST_CLOCK_PRESCALER_PROGRAMMING_MODE_RST;
			else
				fast_presc_r <= FAST_CLOCK_PRESCALER_RST;
			slow_presc_r <= SLOW_CLOCK_PRESCALER_RST;
			aux_presc_r <= AUX_CLOCK_PRESCALER_RST;
		end
		else
		begin
			if (wr_fast)
				fast_presc_r <= req.wdata[6:0];
			if (wr_slow)
				slow_presc_r <= req.wdata;
			if (wr_aux)
				aux_presc_r <= req.wdata;
		end
	end

	// Read multiplexer; unmapped addresses and reserved bits read zero
	wire logic [7:0] rd_mux =
		sel_ctl ? ctl_r :
		sel_fast ? {1'b0, fast_presc_r} :
		sel_slow ? slow_presc_r :
		sel_aux ? aux_presc_r : 8'h00;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			rdata_r <= 8'h00;
		else if (req.rd)
			rdata_r <= rd_mux;
		else
			rdata_r <= 8'h00;
	end

	// Main clock counts only when the oscillator is stable
	wire logic main_tick = main_stable_i;

	// Fast source pulses; select comes from the register itself
	wire logic fast_src_tick =
		ctl_r.fast_source_select ? main_tick : pll_tick_i;
	wire logic fast_wrap = fast_cnt_r == fast_divisor;

	// Fast prescaler: one output pulse per divisor plus one source pulses
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			fast_cnt_r <= 4'h0;
			fast_tick_r <= 1'b0;
		end
		else
		begin
			fast_tick_r <= fast_src_tick && fast_wrap;
			if (fast_src_tick)
				fast_cnt_r <= fast_wrap ? 4'h0 : fast_cnt_r + 4'h1;
		end
	end

	// Slow divider from main: half period is divisor plus one main cycles
	wire logic slow_wrap = slow_cnt_r == slow_divisor;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			slow_cnt_r <= 8'h00;
			slow_div_r <= 1'b0;
		end
		else if (main_tick)
		begin
			slow_cnt_r <= slow_wrap ? 8'h00 : slow_cnt_r + 8'h01;
			if (slow_wrap)
				slow_div_r <= !slow_div_r;
		end
	end

	// Oscillator pin sampled once; it runs in every mode
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			lfo_r <= 1'b0;
		else
			lfo_r <= lfo_clk_i;
	end

	// Glitch-free mux: the source only changes while both levels are low
	wire logic slow_src_lvl = slow_src_r ? lfo_r : slow_div_r;
	wire logic slow_new_lvl = ctl_r.slow_source_select ? lfo_r : slow_div_r;
	wire logic slow_swap = (slow_src_r != ctl_r.slow_source_select) &&
		!slow_clk_r && !slow_new_lvl;
	wire logic halted = mode_r == PM_HALT;
	wire logic slow_rise = !slow_clk_r && slow_src_lvl && !slow_swap && !halted;

	// Slow clock output; frozen low in halt mode
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			slow_src_r <= 1'b0;
			slow_clk_r <= 1'b0;
		end
		else
		begin
			if (slow_swap)
				slow_src_r <= ctl_r.slow_source_select;
			if (halted)
				slow_clk_r <= 1'b0;
			else if (!slow_swap)
				slow_clk_r <= slow_src_lvl;
		end
	end

	// Aux prescalers stop while disabled or the main clock is unstable
	wire logic aux1_run = ctl_r.aux1_enable && main_stable_i;
	wire logic aux2_run = ctl_r.aux2_enable && main_stable_i;
	wire logic aux1_wrap = aux1_cnt_r == aux1_divisor;
	wire logic aux2_wrap = aux2_cnt_r == aux2_divisor;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			aux1_cnt_r <= 4'h0;
			aux1_tick_r <= 1'b0;
		end
		else
		begin
			aux1_tick_r <= aux1_run && aux1_wrap;
			if (!aux1_run)
				aux1_cnt_r <= 4'h0;
			else
				aux1_cnt_r <= aux1_wrap ? 4'h0 : aux1_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			aux2_cnt_r <= 4'h0;
			aux2_tick_r <= 1'b0;
		end
		else
		begin
			aux2_tick_r <= aux2_run && aux2_wrap;
			if (!aux2_run)
				aux2_cnt_r <= 4'h0;
			else
				aux2_cnt_r <= aux2_wrap ? 4'h0 : aux2_cnt_r + 4'h1;
		end
	end

	// Mode tracking; reset always lands in active
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			mode_r <= PM_ACTIVE;
		else
			mode_r <= pm_mode_t'(pm_mode_i);
	end

	// System and timer clock per mode
	logic sys_tick_nxt;
	logic timer_tick_nxt;
	logic hf_en_nxt;

	always_comb
	begin
		sys_tick_nxt = 1'b0;
		timer_tick_nxt = 1'b0;
		hf_en_nxt = 1'b0;
		unique case (mode_r)
			PM_ACTIVE:
			begin
				sys_tick_nxt = fast_tick_r;
				timer_tick_nxt = slow_rise;
				hf_en_nxt = 1'b1;
			end
			PM_SAVE:
			begin
				sys_tick_nxt = slow_rise;
				timer_tick_nxt = slow_rise;
				// Oscillator may only stop once slow clock no longer needs it
				hf_en_nxt = !(hf_off_req_i && slow_src_r &&
					ctl_r.slow_source_select);
			end
			PM_IDLE:
			begin
				timer_tick_nxt = slow_rise;
			end
			PM_HALT:
			begin
				timer_tick_nxt = 1'b0;
			end
		endcase
	end

	// Clock enables and oscillator control
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			sys_tick_r <= 1'b0;
			timer_tick_r <= 1'b0;
			hf_osc_en_r <= 1'b1;
		end
		else
		begin
			sys_tick_r <= sys_tick_nxt;
			timer_tick_r <= timer_tick_nxt;
			hf_osc_en_r <= hf_en_nxt;
		end
	end

	// PLL held down by the bit, and always off in idle and halt
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pll_stop_r <= 1'b1;
		else
			pll_stop_r <= ctl_r.pll_power_down ||
				mode_r == PM_IDLE || halted;
	end

	// Wait stalls issue; an interrupt in the same cycle wins
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			cpu_stall_r <= 1'b0;
		else if (irq_i)
			cpu_stall_r <= 1'b0;
		else if (wait_i)
			cpu_stall_r <= 1'b1;
	end

	// Multiplier code passed straight on; reserved codes are not filtered
	logic [2:0] pll_mult_r;

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pll_mult_r <= PLL_MULT_4X;
		else
			pll_mult_r <= pll_mult;
	end

	// Outputs, all straight from flip-flops
	assign rdata_o = rdata_r;
	assign sys_tick_o = sys_tick_r;
	assign timer_tick_o = timer_tick_r;
	assign slow_clk_o = slow_clk_r;
	assign aux1_tick_o = aux1_tick_r;
	assign aux2_tick_o = aux2_tick_r;
	assign pll_stop_o = pll_stop_r;
	assign pll_mult_o = pll_mult_r;
	assign fast_src_main_o = ctl_r.fast_source_select;
	assign hf_osc_en_o = hf_osc_en_r;
	assign cpu_stall_o = cpu_stall_r;
	assign pm_mode_o = mode_r;

endmodule : clk_ctrl
`default_nettype wire

// ==== testbench/clk_ctrl_sva.sv ====
// Assertion checker for the clock select and prescaler block
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_sva
	import clk_ctrl_pkg::*;
(
	// Clock, reset and register port
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	// Sources and power manager
	input wire logic main_stable_i,
	input wire logic pll_stable_i,
	input wire logic [1:0] pm_mode_i,
	input wire logic wait_i,
	input wire logic irq_i,
	// Watched outputs
	input wire logic sys_tick_o,
	input wire logic timer_tick_o,
	input wire logic slow_clk_o,
	input wire logic aux1_tick_o,
	input wire logic aux2_tick_o,
	input wire logic pll_stop_o,
	input wire logic fast_src_main_o,
	input wire logic hf_osc_en_o,
	input wire logic cpu_stall_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Source interlocks; two-cycle pasts cover registered mode inputs
	fast_pll_a: assert property (
		$fell(fast_src_main_o) |-> $past(pll_stable_i) && $past(wr_i)
		&& $past(addr_i) == CLOCK_RESET_CONTROL_OFS)
		else $error("fast select left main clock without stable PLL");
	pll_run_a: assert property (
		$past(!fast_src_main_o) && $past(pm_mode_i) == PM_ACTIVE
		&& $past(pm_mode_i, 2) == PM_ACTIVE |-> !pll_stop_o)
		else $error("PLL stopped while system clock uses it");
	hf_on_a: assert property (
		(pm_mode_i == PM_ACTIVE)[*2] |=> hf_osc_en_o)
		else $error("oscillator off in active mode");
	idle_nosys_a: assert property (
		(pm_mode_i == PM_IDLE)[*4] |=> !sys_tick_o)
		else $error("system tick in idle mode");
	halt_still_a: assert property (
		(pm_mode_i == PM_HALT)[*2] |=> !slow_clk_o && !timer_tick_o)
		else $error("slow clock moving in halt mode");
	aux1_stop_a: assert property (
		!main_stable_i ##1 !main_stable_i |=> !aux1_tick_o)
		else $error("aux clock 1 ran on unstable main clock");
	aux2_stop_a: assert property (
		!main_stable_i ##1 !main_stable_i |=> !aux2_tick_o)
		else $error("aux clock 2 ran on unstable main clock");
	stall_set_a: assert property (
		wait_i && !irq_i |=> cpu_stall_o)
		else $error("wait did not stall the processor");
	stall_clr_a: assert property (
		irq_i |=> !cpu_stall_o)
		else $error("interrupt did not release the processor");
endmodule : clk_ctrl_sva
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the clock select and prescaler block
`timescale 1ns/1ns
`default_nettype none
module tb;
	import clk_ctrl_pkg::*;
	localparam logic [7:0] CTL = CLOCK_RESET_CONTROL_OFS;
	localparam logic [7:0] FPS = FAST_CLOCK_PRESCALER_OFS;
	// Stimulus, all driven after rising edges
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic main_stable_i = 1'b1;
	logic pll_tick_i = 1'b0;
	logic pll_stable_i = 1'b0;
	logic lfo_clk_i = 1'b0;
	logic power_on_i = 1'b0;
	logic programming_mode_i = 1'b0;
	logic [1:0] pm_mode_i = 2'h0;
	logic hf_off_req_i = 1'b0;
	logic wait_i = 1'b0;
	logic irq_i = 1'b0;
	logic [3:0] lc = 4'h0;
	// Observed outputs
	logic [7:0] rdata_o;
	logic sys_tick_o, timer_tick_o, slow_clk_o, aux1_tick_o, aux2_tick_o;
	logic pll_stop_o, fast_src_main_o, hf_osc_en_o, cpu_stall_o;
	logic [2:0] pll_mult_o;
	logic [1:0] pm_mode_o;
	int miscompares = 0;
	int samples_checked = 0;
	wire [3:0] taps = {aux2_tick_o, aux1_tick_o, timer_tick_o, sys_tick_o};

	clk_ctrl u_clk_ctrl (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
		.rdata_o, .main_stable_i, .pll_tick_i, .pll_stable_i, .lfo_clk_i,
		.power_on_i, .programming_mode_i, .pm_mode_i, .hf_off_req_i,
		.wait_i, .irq_i, .sys_tick_o, .timer_tick_o, .slow_clk_o,
		.aux1_tick_o, .aux2_tick_o, .pll_stop_o, .pll_mult_o,
		.fast_src_main_o, .hf_osc_en_o, .cpu_stall_o, .pm_mode_o);

	always #50 mclk_i = ~mclk_i;

	// Stand-ins: oscillator of period 16, PLL ticking every other cycle
	always @(posedge mclk_i)
	begin
		lc <= lc + 4'h1;
		lfo_clk_i <= lc[3];
		pll_tick_i <= ~pll_tick_i;
	end

	task automatic close_out;
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask : rd

	// Cycles between two pulses of one tap
	task automatic gap(input int s, input int exp);
		int n;
		int w;
		n = 0;
		w = 0;
		while (w < 300 && taps[s] !== 1'b1)
		begin
			@(posedge mclk_i);
			#1 w++;
		end
		do
		begin
			@(posedge mclk_i);
			#1 n++;
		end
		while (n < 300 && taps[s] !== 1'b1);
		chk(8'(n), 8'(exp));
	endtask : gap

	// Pulses of one tap over a span; unknown counts as a pulse
	task automatic cnt(input int s, input int cyc, input int exp);
		int k;
		k = 0;
		repeat (cyc)
		begin
			@(posedge mclk_i);
			#1 if (taps[s] !== 1'b0) k++;
		end
		chk(8'(k), 8'(exp));
	endtask : cnt

	task automatic t_reset;
		rd(CTL, 8'h26);
		rd(FPS, 8'h4f);
		rd(SLOW_CLOCK_PRESCALER_OFS, 8'hb6);
		rd(AUX_CLOCK_PRESCALER_OFS, 8'hff);
		rd(8'h48, 8'h00);
		chk(8'(pll_mult_o), 8'h04);
		chk(8'(pll_stop_o), 8'h01);
	endtask : t_reset

	// Multiplier changed only while running from the oscillator
	task automatic t_fast;
		wr(CTL, 8'h27);
		pm_mode_i <= PM_SAVE;
		for (int m = 3; m < 6; m++)
		begin
			wr(FPS, {1'b1, 3'(m), 4'h3});
			rd(FPS, {1'b0, 3'(m), 4'h3});
			chk(8'(pll_mult_o), 8'(m));
		end
		pm_mode_i <= PM_ACTIVE;
		wr(CTL, 8'h26);
		wr(CTL, 8'h24);
		rd(CTL, 8'h26);
		wr(CTL, 8'h20);
		rd(CTL, 8'h22);
		chk(8'(pll_stop_o), 8'h00);
		wr(CTL, 8'h20);
		rd(CTL, 8'h22);
		@(posedge mclk_i);
		pll_stable_i <= 1'b1;
		wr(CTL, 8'h20);
		rd(CTL, 8'h20);
		chk(8'(fast_src_main_o), 8'h00);
		wr(CTL, 8'h24);
		rd(CTL, 8'h20);
		wr(CTL, 8'h26);
		rd(CTL, 8'h22);
		wr(CTL, 8'h26);
		rd(CTL, 8'h26);
		chk(8'(pll_stop_o), 8'h01);
	endtask : t_fast

	task automatic t_por;
		wr(CTL, 8'h06);
		rd(CTL, 8'h06);
		wr(CTL, 8'h26);
		rd(CTL, 8'h06);
		@(posedge mclk_i);
		power_on_i <= 1'b1;
		@(posedge mclk_i);
		power_on_i <= 1'b0;
		rd(CTL, 8'h26);
	endtask : t_por

	task automatic t_aux;
		wr(AUX_CLOCK_PRESCALER_OFS, 8'h32);
		wr(CTL, 8'h3e);
		gap(2, 3);
		gap(3, 4);
		@(posedge mclk_i);
		main_stable_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		cnt(2, 20, 0);
		cnt(3, 20, 0);
		main_stable_i <= 1'b1;
		wr(CTL, 8'h26);
		repeat (2) @(posedge mclk_i);
		cnt(2, 20, 0);
		cnt(3, 20, 0);
	endtask : t_aux

	// Divided clocks per source and per mode
	task automatic t_clk;
		gap(0, 4);
		wr(SLOW_CLOCK_PRESCALER_OFS, 8'h03);
		gap(1, 8);
		wr(CTL, 8'h27);
		repeat (40) @(posedge mclk_i);
		gap(1, 16);
		pm_mode_i <= PM_SAVE;
		hf_off_req_i <= 1'b1;
		// Let a last fast pulse from active mode drain first
		repeat (3) @(posedge mclk_i);
		gap(0, 16);
		chk(8'(hf_osc_en_o), 8'h00);
		wr(CTL, 8'h26);
		rd(CTL, 8'h26);
		chk(8'(hf_osc_en_o), 8'h01);
		pm_mode_i <= PM_IDLE;
		repeat (4) @(posedge mclk_i);
		#1 chk(8'(pm_mode_o), 8'h02);
		cnt(0, 30, 0);
		gap(1, 8);
		pm_mode_i <= PM_HALT;
		repeat (4) @(posedge mclk_i);
		cnt(1, 40, 0);
		pm_mode_i <= PM_ACTIVE;
		wait_i <= 1'b1;
		@(posedge mclk_i);
		wait_i <= 1'b0;
		#1 chk(8'(cpu_stall_o), 8'h01);
		@(posedge mclk_i);
		irq_i <= 1'b1;
		@(posedge mclk_i);
		irq_i <= 1'b0;
		#1 chk(8'(cpu_stall_o), 8'h00);
	endtask : t_clk

	// Mid-run reset with programming mode high
	task automatic t_programming_mode;
		@(posedge mclk_i);
		rst_i <= 1'b1;
		programming_mode_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		programming_mode_i <= 1'b0;
		rd(FPS, 8'h40);
		rd(CTL, 8'h26);
		chk(8'(pm_mode_o), 8'h00);
	endtask : t_programming_mode

	initial
	begin
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_reset;
		t_fast;
		t_por;
		t_aux;
		t_clk;
		t_programming_mode;
		close_out;
	end

	// Watchdog at 20000 cycles, far beyond the expected few hundred cycles
	initial
	begin
		#2000000;
		miscompares++;
		close_out;
	end
endmodule : tb

bind clk_ctrl clk_ctrl_sva u_clk_ctrl_sva (.mclk_i, .rst_i, .addr_i, .wr_i,
	.main_stable_i, .pll_stable_i, .pm_mode_i, .wait_i, .irq_i, .sys_tick_o,
	.timer_tick_o, .slow_clk_o, .aux1_tick_o, .aux2_tick_o, .pll_stop_o,
	.fast_src_main_o, .hf_osc_en_o, .cpu_stall_o);
`default_nettype wire
